//--- sar_ctrl_pkg.sv
// constants and types shared by both ends of the conversion link
//
// What this block does
// [RULE1] start only after acquisition and start strobe low
// [RULE2] successive approximation, msb first, sixteen trials
// [RULE3] trials done: form code, drop busy
// [RULE4] both selects high: wideband fast, 3 msps
// [RULE5] fast high, low-power low: fast, 3 msps
// [RULE6] both low: normal, 2 msps, no interval limit
// [RULE7] fast low, low-power high: low-power, 1.25 msps
// [RULE8] low-power mode powers down after each conversion
// [RULE9] host keeps fast-mode start interval within 1 ms; the host only counts the gap, starts follow go_i
// [RULE10] host discards first fast result after 1 ms gap; the host passes it out with data_stale_o set
// [RULE11] result belongs to its own start, no latency
// [RULE12] sample taken at start strobe falling edge
// [RULE13] reset aborts; release runs calibration with busy pulse
// [RULE14] power-down finishes current conversion then inhibits
// [RULE15] busy high from start until result ready
// [RULE16] start strobe ignored while converting
package sar_ctrl_pkg;

    localparam int unsigned CLK_PERIOD_NS   = 8;
    localparam int unsigned RES_BITS        = 16;
    localparam int unsigned FULL_SCALE      = 65536;
    // conversion periods in ns per mode (throughput limits)
    localparam int unsigned PERIOD_FAST_NS  = 333;   // 3 msps
    localparam int unsigned PERIOD_NORM_NS  = 500;   // 2 msps
    localparam int unsigned PERIOD_LP_NS    = 800;   // 1.25 msps
    // least periods round up to whole cycles
    localparam int unsigned PERIOD_FAST_CYC = (PERIOD_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PERIOD_NORM_CYC = (PERIOD_NORM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PERIOD_LP_CYC   = (PERIOD_LP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned IDLE_LIMIT_MS   = 1;
    localparam int unsigned IDLE_LIMIT_CYC  = IDLE_LIMIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned ACQ_CYC         = 4;
    localparam int unsigned CAL_CYC         = 32;
    localparam int unsigned WAKE_CYC        = 4;

    typedef enum logic [1:0] {
        MODE_NORMAL   = 2'h0,
        MODE_LOWPOWER = 2'h1,
        MODE_FAST     = 2'h2,
        MODE_WIDEBAND = 2'h3
    } conv_mode_t;

    typedef enum logic [5:0] {
        ST_CAL   = 6'h01,
        ST_ACQ   = 6'h02,
        ST_READY = 6'h04,
        ST_TRIAL = 6'h08,
        ST_PAD   = 6'h10,
        ST_SLEEP = 6'h20
    } conv_state_t;

endpackage : sar_ctrl_pkg

//--- sar_link_if.sv
// pins between host controller and converter control
`timescale 1ns/100ps
interface sar_link_if;
    logic        conversion_start_n;
    logic        fast_sel;
    logic        lowpower_sel;
    logic        power_down_in;
    logic        reset_in;
    logic        busy;
    logic [15:0] result;

    modport device
    (
        input  conversion_start_n,
        input  fast_sel,
        input  lowpower_sel,
        input  power_down_in,
        input  reset_in,
        output busy,
        output result
    );

    modport host
    (
        output conversion_start_n,
        output fast_sel,
        output lowpower_sel,
        output power_down_in,
        output reset_in,
        input  busy,
        input  result
    );
endinterface : sar_link_if

//--- sar_conversion_mode_control.sv
// converter control end: sequencer, mode timing and result register
`timescale 1ns/100ps
module sar_conversion_mode_control
    import sar_ctrl_pkg::*;
#(
    parameter int unsigned NBITS = RES_BITS
)
(
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    sar_link_if.device            link,
    input  wire logic [NBITS-1:0] sample_i,
    input  wire logic             comp_i,
    output logic                  hold_o,
    output logic [NBITS-1:0]      dac_o,
    output logic                  powered_o
);

    conv_state_t      state_q, state_d;
    logic [NBITS-1:0] sar_q, sar_d;
    logic [NBITS-1:0] bit_q, bit_d;
    logic [NBITS-1:0] held_q, held_d;
    logic [NBITS-1:0] res_q, res_d;
    logic [9:0]       cnt_q, cnt_d;
    logic             busy_q, busy_d;
    logic             start_q, start_d;
    conv_mode_t       mode;
    logic             fall;
    logic             cmp;
    logic [9:0]       pad_cyc;

    assign mode = conv_mode_t'({link.fast_sel, link.lowpower_sel});
    assign fall = start_q & ~link.conversion_start_n;   // [RULE12]

    // comparator: internal model against held sample when no analog front end
    assign cmp  = comp_i | (held_q >= (sar_q | bit_q));

    always_comb
    begin
        case (mode)
            MODE_WIDEBAND: pad_cyc = 10'(PERIOD_FAST_CYC);   // [RULE4]
            MODE_FAST:     pad_cyc = 10'(PERIOD_FAST_CYC);   // [RULE5]
            MODE_NORMAL:   pad_cyc = 10'(PERIOD_NORM_CYC);   // [RULE6]
            default:       pad_cyc = 10'(PERIOD_LP_CYC);     // [RULE7]
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        state_d = state_q;
        sar_d   = sar_q;
        bit_d   = bit_q;
        held_d  = held_q;
        res_d   = res_q;
        cnt_d   = cnt_q;
        busy_d  = busy_q;
        start_d = link.conversion_start_n;
        case (state_q)
            ST_CAL:
            begin
                busy_d = 1'b1;   // [RULE13]
                cnt_d  = cnt_q + 10'h001;
                // busy set on every cal cycle but the last, so the pulse is exactly CAL_CYC long
                if (cnt_q == 10'(CAL_CYC))
                begin
                    busy_d  = 1'b0;
                    cnt_d   = '0;
                    state_d = ST_ACQ;
                end
            end
            ST_ACQ:
            begin
                cnt_d = cnt_q + 10'h001;
                if (cnt_q == 10'(ACQ_CYC - 1))
                begin
                    cnt_d   = '0;
                    state_d = ST_READY;
                end
            end
            ST_READY:
            begin
                // strobes before acquisition ends are simply missed
                if (fall && !link.power_down_in)   // [RULE1] [RULE14]
                begin
                    held_d  = sample_i;   // [RULE11] [RULE12]
                    sar_d   = '0;
                    bit_d   = {1'b1, {(NBITS-1){1'b0}}};   // [RULE2]
                    busy_d  = 1'b1;   // [RULE15]
                    cnt_d   = 10'(NBITS + 1);
                    state_d = ST_TRIAL;
                end
            end
            ST_TRIAL:
            begin
                // strobes here are ignored by state [RULE16]
                if (cmp)
                    sar_d = sar_q | bit_q;   // [RULE2]
                bit_d = bit_q >> 1;
                if (bit_q[0])
                begin
                    res_d   = cmp ? (sar_q | bit_q) : sar_q;   // [RULE3] [RULE11]
                    busy_d  = 1'b0;   // [RULE3]
                    state_d = ST_PAD;
                end
            end
            ST_PAD:
            begin
                // stretch to the mode's period; covers acquisition too
                cnt_d = cnt_q + 10'h001;
                if (cnt_q >= pad_cyc)
                begin
                    cnt_d   = '0;
                    state_d = (mode == MODE_LOWPOWER) ? ST_SLEEP : ST_READY;   // [RULE8]
                end
            end
            ST_SLEEP:
            begin
                // wake latency paid on the next start window
                cnt_d = cnt_q + 10'h001;
                if (cnt_q == 10'(WAKE_CYC - 1))
                begin
                    cnt_d   = '0;
                    state_d = ST_READY;
                end
            end
            default:
            begin
                state_d = ST_CAL;
                cnt_d   = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q  <= ST_CAL;
            sar_q    <= '0;
            bit_q    <= '0;
            held_q   <= '0;
            res_q    <= '0;
            cnt_q    <= '0;
            busy_q   <= 1'b0;
            start_q  <= 1'b1;
        end
        else if (link.reset_in)
        begin
            // abort; calibration starts when reset falls
            state_q  <= ST_CAL;   // [RULE13]
            cnt_q    <= '0;
            busy_q   <= 1'b0;
            bit_q    <= '0;
            start_q  <= 1'b1;
        end
        else
        begin
            state_q  <= state_d;
            sar_q    <= sar_d;
            bit_q    <= bit_d;
            held_q   <= held_d;
            res_q    <= res_d;
            cnt_q    <= cnt_d;
            busy_q   <= busy_d;
            start_q  <= start_d;
        end
    end

    assign link.busy   = busy_q;
    assign link.result = res_q;
    assign hold_o      = (state_q == ST_TRIAL);
    assign dac_o       = sar_q | bit_q;
    assign powered_o   = (state_q != ST_SLEEP) && !link.power_down_in;

endmodule : sar_conversion_mode_control

//--- sar_host_control.sv
// host end: drives mode pins and start strobe, collects results
`timescale 1ns/100ps
module sar_host_control
    import sar_ctrl_pkg::*;
#(
    parameter int unsigned IDLE_LIMIT = IDLE_LIMIT_CYC
)
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    sar_link_if.host         link,
    input  wire logic        go_i,
    input  wire logic [1:0]  mode_i,
    input  wire logic        pd_i,
    input  wire logic        dev_reset_i,
    output logic             ready_o,
    output logic [15:0]      data_o,
    output logic             data_valid_o,
    output logic             data_stale_o
);

    typedef enum logic [2:0] {
        H_IDLE = 3'h1,
        H_LOW  = 3'h2,
        H_WAIT = 3'h4
    } host_state_t;

    host_state_t st_q, st_d;
    logic        cnv_q, cnv_d;
    logic [15:0] data_q, data_d;
    logic        val_q, val_d;
    logic        stale_q, stale_d;
    logic        first_q, first_d;
    logic [31:0] idle_q, idle_d;
    logic        seen_q, seen_d;
    logic        fast;

    assign fast = mode_i[1];

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_d    = st_q;
        cnv_d   = cnv_q;
        data_d  = data_q;
        val_d   = 1'b0;
        stale_d = stale_q;
        first_d = first_q;
        seen_d  = seen_q;
        idle_d  = (idle_q < IDLE_LIMIT) ? idle_q + 32'h1 : idle_q;
        case (st_q)
            H_IDLE:
            begin
                if (go_i && !link.busy)
                begin
                    cnv_d   = 1'b0;
                    // long gap in fast modes taints the next result
                    first_d = fast && (idle_q >= IDLE_LIMIT);   // [RULE9] [RULE10]
                    idle_d  = '0;
                    seen_d  = 1'b0;
                    st_d    = H_LOW;
                end
            end
            H_LOW:
            begin
                cnv_d = 1'b1;
                st_d  = H_WAIT;
            end
            H_WAIT:
            begin
                if (link.busy)
                    seen_d = 1'b1;
                if (seen_q && !link.busy)
                begin
                    data_d  = link.result;
                    val_d   = 1'b1;
                    stale_d = first_q;   // [RULE10]
                    st_d    = H_IDLE;
                end
            end
            default:
            begin
                st_d  = H_IDLE;
                cnv_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q    <= H_IDLE;
            cnv_q   <= 1'b1;
            data_q  <= '0;
            val_q   <= 1'b0;
            stale_q <= 1'b0;
            first_q <= 1'b0;
            idle_q  <= '0;
            seen_q  <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            cnv_q   <= cnv_d;
            data_q  <= data_d;
            val_q   <= val_d;
            stale_q <= stale_d;
            first_q <= first_d;
            idle_q  <= idle_d;
            seen_q  <= seen_d;
        end
    end

    assign link.conversion_start_n = cnv_q;
    assign link.fast_sel           = mode_i[1];
    assign link.lowpower_sel       = mode_i[0];
    assign link.power_down_in      = pd_i;
    assign link.reset_in           = dev_reset_i;
    assign ready_o                 = (st_q == H_IDLE) && !link.busy;
    assign data_o                  = data_q;
    assign data_valid_o            = val_q;
    assign data_stale_o            = stale_q;

endmodule : sar_host_control

//--- sar_link_checker.sv
// assertions on the pins between host end and converter end
`timescale 1ns/100ps
module sar_link_checker
    import sar_ctrl_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        conversion_start_n,
    input  wire logic        fast_sel,
    input  wire logic        lowpower_sel,
    input  wire logic        power_down_in,
    input  wire logic        reset_in,
    input  wire logic        busy,
    input  wire logic [15:0] result
);
    logic       busy_q;
    logic [5:0] len_q;
    logic [7:0] idle_q;
    logic       conv_end;
    logic       take_seen;

    ////////////////////////////////////////////////////////////////////////////////
    // helper counters: busy length and idle gap since last conversion
    assign conv_end  = busy_q && !busy && (len_q == 6'h10);
    assign take_seen = busy && !busy_q;
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            busy_q <= 1'b0;
            len_q  <= 6'h0;
            idle_q <= 8'hff;
        end
        else
        begin
            busy_q <= busy;
            len_q  <= busy ? len_q + 6'h1 : 6'h0;
            // saturate so a gap after calibration never looks short
            if (reset_in)
                idle_q <= 8'hff;
            else if (conv_end)
                idle_q <= 8'h01;
            else if (idle_q != 8'hff)
                idle_q <= idle_q + 8'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // properties
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i || reset_in);

    property p_conv_len;
        $rose(busy) && !$past(conversion_start_n) |-> ##15 busy ##1 !busy;
    endproperty
    a_conv_len : assert property (p_conv_len) else $error("conversion busy not 16 cycles");
    property p_busy_len;
        busy_q && !busy |-> (len_q == 6'h10) || (len_q == 6'h20);
    endproperty
    a_busy_len : assert property (p_busy_len) else $error("busy pulse of wrong length");
    property p_result_hold;
        !(busy_q && !busy) |-> $stable(result);
    endproperty
    a_result_hold : assert property (p_result_hold) else $error("result moved mid-run");
    property p_cal_start;
        disable iff (!rst_n_i) $fell(reset_in) |-> ##[1:2] busy;
    endproperty
    a_cal_start : assert property (p_cal_start) else $error("no calibration busy");
    property p_abort;
        disable iff (!rst_n_i) reset_in |=> !busy;
    endproperty
    a_abort : assert property (p_abort) else $error("busy kept during reset");
    property p_pd_inhibit;
        power_down_in && !busy |=> !busy;
    endproperty
    a_pd_inhibit : assert property (p_pd_inhibit) else $error("start under power-down");
    // gap runs from busy fall; the 16 busy cycles make it start to start, and the check adds one cycle more
    property p_gap_fast;
        take_seen && fast_sel |-> (int'(idle_q) + RES_BITS + 1) >= PERIOD_FAST_CYC;
    endproperty
    a_gap_fast : assert property (p_gap_fast) else $error("fast mode too quick");
    property p_gap_norm;
        take_seen && !fast_sel && !lowpower_sel |-> (int'(idle_q) + RES_BITS + 1) >= PERIOD_NORM_CYC;
    endproperty
    a_gap_norm : assert property (p_gap_norm) else $error("normal mode too quick");
    property p_gap_lp;
        take_seen && !fast_sel && lowpower_sel |-> (int'(idle_q) + RES_BITS + 1) >= PERIOD_LP_CYC;
    endproperty
    a_gap_lp : assert property (p_gap_lp) else $error("low-power mode too quick");

    c_conv : cover property ($rose(busy) && !$past(conversion_start_n));
    c_cal  : cover property (disable iff (!rst_n_i) $fell(reset_in) ##2 busy);
    c_lp   : cover property (conv_end && lowpower_sel);
endmodule : sar_link_checker

//--- sar_conversion_mode_control_test.sv
// testbench: host end and converter end joined over the link
`timescale 1ns/100ps
module sar_conversion_mode_control_test;
    import sar_ctrl_pkg::*;
    localparam int unsigned IDLE_LIM = 200;
    localparam logic [15:0] VALS [4] = '{16'h8000, 16'h0001, 16'hffff, 16'h5a5a};
    logic        sys_clk_i       = 1'b0;
    logic        rst_n_i         = 1'b0;
    logic        go              = 1'b0;
    logic        pd              = 1'b0;
    logic        dev_rst         = 1'b0;
    logic [1:0]  mode            = 2'h0;
    logic [15:0] sample          = 16'h0;
    logic [15:0] sample_b        = 16'h0;
    logic        valid;
    logic        stale;
    logic        powered;
    logic [15:0] data;
    int          err_count       = 0;
    int          samples_checked = 0;

    always #4 sys_clk_i = ~sys_clk_i;

    ////////////////////////////////////////////////////////////////////////////////
    // both ends, plus a bare converter end driven by hand
    sar_link_if link ();
    sar_link_if link_b ();
    sar_conversion_mode_control u_sar_conversion_mode_control (.sys_clk_i (sys_clk_i),
        .rst_n_i (rst_n_i), .link (link.device), .sample_i (sample), .comp_i (1'b0),
        .hold_o (), .dac_o (), .powered_o (powered));
    sar_conversion_mode_control u_sar_conversion_mode_control_b (.sys_clk_i (sys_clk_i),
        .rst_n_i (rst_n_i), .link (link_b.device), .sample_i (sample_b), .comp_i (1'b0),
        .hold_o (), .dac_o (), .powered_o ());
    sar_host_control #(.IDLE_LIMIT (IDLE_LIM)) u_sar_host_control (.sys_clk_i (sys_clk_i),
        .rst_n_i (rst_n_i), .link (link.host), .go_i (go), .mode_i (mode), .pd_i (pd),
        .dev_reset_i (dev_rst), .ready_o (), .data_o (data), .data_valid_o (valid),
        .data_stale_o (stale));
    sar_link_checker u_sar_link_checker (.sys_clk_i (sys_clk_i), .rst_n_i (rst_n_i),
        .conversion_start_n (link.conversion_start_n), .fast_sel (link.fast_sel),
        .lowpower_sel (link.lowpower_sel), .power_down_in (link.power_down_in),
        .reset_in (link.reset_in), .busy (link.busy), .result (link.result));

    ////////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic end_sim;
        if (err_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    // input changes after busy rises, so a late sample shows as a wrong code
    task automatic do_conv(input logic [15:0] v);
        int i;
        @(negedge sys_clk_i);
        sample = v;
        go = 1'b1;
        for (i = 0; i < 400 && link.busy !== 1'b1; i++) @(negedge sys_clk_i);
        go = 1'b0;
        sample = ~v;
        for (i = 0; i < 400 && valid !== 1'b1; i++) @(negedge sys_clk_i);
        check("data_o", v, data);
    endtask : do_conv

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_modes;
        int m;
        int j;
        int i;
        for (m = 0; m < 4; m++)
        begin
            mode = m[1:0];
            repeat (110) @(negedge sys_clk_i);
            check("fast_sel", {15'h0, mode[1]}, {15'h0, link.fast_sel});
            check("lowpower_sel", {15'h0, mode[0]}, {15'h0, link.lowpower_sel});
            for (j = 0; j < 2; j++)
            begin
                do_conv(VALS[m] ^ j[15:0]);
                // low-power sleeps only once the pad has run out
                for (i = 0; i < 120 && powered !== (m != 1); i++) @(negedge sys_clk_i);
                check("powered_o", {15'h0, m != 1}, {15'h0, powered});
                // strobes inside the pad are lost, so let it run out
                repeat (110) @(negedge sys_clk_i);
            end
        end
    endtask : t_modes

    task automatic t_stale;
        mode = 2'h2;
        repeat (IDLE_LIM + 50) @(negedge sys_clk_i);
        do_conv(16'h1234);
        check("data_stale_o", 16'h1, {15'h0, stale});
        repeat (110) @(negedge sys_clk_i);
        do_conv(16'h4321);
        check("data_stale_o", 16'h0, {15'h0, stale});
    endtask : t_stale

    task automatic t_abort;
        int i;
        int hi;
        mode = 2'h0;
        repeat (70) @(negedge sys_clk_i);
        go = 1'b1;
        for (i = 0; i < 400 && link.busy !== 1'b1; i++) @(negedge sys_clk_i);
        go = 1'b0;
        repeat (5) @(negedge sys_clk_i);
        dev_rst = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        check("busy", 16'h0, {15'h0, link.busy});
        dev_rst = 1'b0;
        hi = 0;
        for (i = 0; i < 60; i++)
        begin
            @(negedge sys_clk_i);
            hi += (link.busy === 1'b1);
        end
        check("cal_busy_cycles", 16'h20, hi[15:0]);
        do_conv(16'h2468);
    endtask : t_abort

    // a host that breaks the rules: strobes mid-run and under power-down
    task automatic t_link_b;
        int i;
        int hi;
        hi = 0;
        sample_b = 16'h9e37;
        link_b.conversion_start_n = 1'b0;
        @(negedge sys_clk_i);
        sample_b = 16'h0f0f;
        for (i = 0; i < 40; i++)
        begin
            hi += (link_b.busy === 1'b1);
            link_b.conversion_start_n = (i != 4);
            if (i == 8)
                link_b.power_down_in = 1'b1;
            @(negedge sys_clk_i);
        end
        check("busy_cycles", 16'h10, hi[15:0]);
        check("result", 16'h9e37, link_b.result);
        hi = 0;
        for (i = 0; i < 100; i++)
        begin
            link_b.conversion_start_n = i[0];
            @(negedge sys_clk_i);
            hi += (link_b.busy === 1'b1);
        end
        check("busy_cycles_pd", 16'h0, hi[15:0]);
        link_b.power_down_in = 1'b0;
        link_b.conversion_start_n = 1'b1;
        repeat (10) @(negedge sys_clk_i);
        link_b.conversion_start_n = 1'b0;
        @(negedge sys_clk_i);
        link_b.conversion_start_n = 1'b1;
        repeat (20) @(negedge sys_clk_i);
        check("result", 16'h0f0f, link_b.result);
    endtask : t_link_b

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial
    begin
        link_b.conversion_start_n = 1'b1;
        link_b.fast_sel = 1'b0;
        link_b.lowpower_sel = 1'b0;
        link_b.power_down_in = 1'b0;
        link_b.reset_in = 1'b0;
        repeat (10) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        t_modes;
        t_stale;
        t_abort;
        t_link_b;
        end_sim;
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        err_count++;
        end_sim;
    end
endmodule : sar_conversion_mode_control_test
